// ---- hw/dmacc_addr_step.sv ----
`timescale 1ns/1ps
module dmacc_addr_step #(
  parameter int AW = 32,
  parameter int IW = 16
) (
  // Start address and step controls
  input  wire logic [AW-1:0] start,
  input  wire logic [IW-1:0] idx,
  input  wire logic          inc,
  input  wire logic [1:0]    width,
  // Address of the item selected by idx
  output logic      [AW-1:0] addr
);
  import dmacc_pkg::*;

  // Index must fit inside the address it offsets
  generate
    if (IW < 1 || AW < IW) begin : g_bad
      $error("IW must be at least 1 and no wider than AW");
    end
  endgenerate

  logic [AW-1:0] idx_ext;
  logic [1:0]    shift;
  logic [AW-1:0] offset;

  // Item size 1, 2 or 4 bytes; reserved width steps as one byte
  assign shift   = (width == WIDTH_RSVD) ? 2'h0 : width;
  assign idx_ext = AW'(idx);
  assign offset  = idx_ext << shift;
  assign addr    = start + (inc ? offset : '0);

endmodule

// ---- hw/dmacc_arbiter.sv ----
`timescale 1ns/1ps
module dmacc_arbiter #(
  parameter int NUM_CH = 8,
  parameter int PW     = 3
) (
  // Requests and priority levels of all channels
  input  wire logic [NUM_CH-1:0]    req,
  input  wire logic [NUM_CH*PW-1:0] prio,
  // One-hot grant
  output logic      [NUM_CH-1:0]    grant
);

  // At least one channel and one level bit are needed
  generate
    if (NUM_CH < 1 || PW < 1) begin : g_bad
      $error("NUM_CH and PW must be at least 1");
    end
  endgenerate

  genvar k;
  // A channel loses to a higher level, or to a lower number at equal level
  generate
    for (k = 0; k < NUM_CH; k++) begin : g_ch
      logic beaten;
      always_comb begin
        beaten = 1'b0;
        for (int j = 0; j < NUM_CH; j++) begin
          if (req[j] && (prio[j*PW +: PW] > prio[k*PW +: PW] ||
              (prio[j*PW +: PW] == prio[k*PW +: PW] && j < k))) begin
            beaten = 1'b1;
          end
        end
        grant[k] = req[k] & ~beaten;
      end
    end
  endgenerate

endmodule

// ---- hw/dmacc_channel.sv ----
// Operation
// - Read-only item index, cleared at completion
// - Addresses from index, step enables, width
// - Source start address in two halves
// - Destination start address in two halves
// - Interrupt when match count equals old index
// - Interrupt only with interrupt enable set
// - Length N moves N plus one items
// - Fill mode fetches source once only
// - Fill run is never broken by others
// - Blocking mode copies back-to-back, locks bus
// - Yield mode waits one cycle after each store but the last
// - Peripheral triggering ignores the yield bit
// - Highest priority level wins the bus
// - Equal levels: lowest channel number wins
// - Normal mode stops and clears run bit
// - Circular mode with triggering keeps running and restarts
// - Source steps 1, 2 or 4 bytes
// - Destination steps by the item size
// - Start at once, or wait for request
// - Width field selects 1, 2, 4 bytes
// - Run bit off holds the channel idle
`timescale 1ns/1ps
module dmacc_channel #(
  parameter int NUM_CH = 8,
  parameter int CH_ID  = 0
) (
  // Clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RST,
  // Avalon-MM register slave
  input  wire dmacc_pkg::dmacc_av_t       AV_IN,
  output logic      [31:0]                AV_READDATA,
  output logic                            AV_WAITREQUEST,
  // System bus master side
  output dmacc_pkg::dmacc_mem_t           MEM_OUT,
  input  wire logic [31:0]                MEM_RDATA,
  input  wire logic                       MEM_ACK,
  output logic                            BUS_LOCK,
  // Peripheral trigger
  input  wire logic                       PERIPH_REQ,
  // Requests and levels of the other channels
  input  wire logic [NUM_CH-1:0]          PEER_REQ,
  input  wire logic [NUM_CH*3-1:0]        PEER_PRIO,
  // Events and status
  output logic                            CH_IRQ,
  output logic                            CH_DONE,
  output logic                            CH_ACTIVE
);
  import dmacc_pkg::*;

  // Channel number must name one of the arbitrated channels
  generate
    if (NUM_CH < 1 || CH_ID < 0 || CH_ID >= NUM_CH) begin : g_bad
      $error("CH_ID outside the channel range");
    end
  endgenerate

  logic [15:0]     cfg_reg [1:6];
  logic [15:0]     ctrl_reg;
  logic [15:0]     ctrl_next;
  logic [15:0]     idx_reg;
  logic [15:0]     idx_next;
  dmacc_state_t    state_reg;
  dmacc_state_t    state_next;
  dmacc_mem_t      mem_reg;
  dmacc_mem_t      mem_next;
  logic [31:0]     data_reg, data_next;
  logic            hold_reg, hold_next;
  logic            irq_reg, irq_next;
  logic            done_reg, done_next;
  logic            resp_reg;
  logic [31:0]     rdata_reg;
  logic            run_clear;
  logic            own_req;
  logic            own_grant;
  logic [NUM_CH-1:0]   req_vec;
  logic [NUM_CH*3-1:0] prio_vec;
  logic [NUM_CH-1:0]   grant_vec;

  // Control fields
  wire logic       run     = ctrl_reg[CB_RUN];
  wire logic [1:0] width   = ctrl_reg[CB_WIDTH +: 2];
  wire logic       irq_en  = ctrl_reg[CB_IRQ_EN];
  wire logic       trig    = ctrl_reg[CB_TRIG];
  wire logic       dst_inc = ctrl_reg[CB_DST_INC];
  wire logic       src_inc = ctrl_reg[CB_SRC_INC];
  wire logic       circ    = ctrl_reg[CB_CIRC];
  wire logic [2:0] prio    = ctrl_reg[CB_PRIO +: PRIO_W];
  wire logic       yield   = ctrl_reg[CB_YIELD];
  wire logic       fill    = ctrl_reg[CB_FILL];

  // Decoded behaviour of the current item
  wire logic [31:0] src_start = {cfg_reg[RI_SRC_HI], cfg_reg[RI_SRC_LO]};
  wire logic [31:0] dst_start = {cfg_reg[RI_DST_HI], cfg_reg[RI_DST_LO]};
  wire logic [15:0] len_w     = cfg_reg[RI_LEN];
  wire logic [15:0] icnt_w    = cfg_reg[RI_INT_CNT];
  wire logic        last      = (idx_reg == len_w);
  wire logic        gap       = yield & ~trig;
  wire logic        keep      = circ & trig;

  // Avalon decode: answer on the second edge of each request
  wire logic   av_req   = AV_IN.read | AV_IN.write;
  wire logic   wr_acc   = AV_IN.write & resp_reg;
  wire logic   rd_first = AV_IN.read & ~resp_reg;
  wire logic   cfg_hit  = (AV_IN.address >= RI_SRC_LO) && (AV_IN.address <= RI_LEN);
  wire logic   sw_ctrl  = wr_acc && (AV_IN.address == RI_CTRL);
  logic [15:0] wr_merged;
  logic [15:0] rd_mux;
  logic [15:0] cfg_rd;
  assign AV_WAITREQUEST = av_req & ~resp_reg;
  assign AV_READDATA    = rdata_reg;

  // Byte lanes 0 and 1 carry the 16-bit register; upper lanes ignored
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  assign wr_merged = (AV_IN.address == RI_CTRL) ?
                     merge16(ctrl_reg, AV_IN.writedata, AV_IN.byteenable) :
                     merge16(cfg_rd, AV_IN.writedata, AV_IN.byteenable);
  assign cfg_rd = cfg_hit ? cfg_reg[AV_IN.address[2:0]] : REG_RESET;

  // Read mux; unmapped words read zero
  assign rd_mux = (AV_IN.address == RI_ITEM_IDX) ? idx_reg :
                  (AV_IN.address == RI_CTRL)     ? ctrl_reg : cfg_rd;

  // Software write wins over the completion clear of the run bit
  assign ctrl_next = sw_ctrl   ? (wr_merged & CTRL_WMASK) :
                     run_clear ? (ctrl_reg & ~(16'h0001 << CB_RUN)) :
                                 ctrl_reg;

  // Slave response and read data
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      resp_reg  <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      resp_reg  <= av_req & ~resp_reg;
      if (rd_first) begin
        rdata_reg <= {16'h0000, rd_mux};
      end
    end
  end

  // Configuration storage, indexed by word
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int i = 1; i <= 6; i++) begin
        cfg_reg[i] <= REG_RESET;
      end
      ctrl_reg <= REG_RESET;
    end else begin
      if (wr_acc && cfg_hit) begin
        cfg_reg[AV_IN.address[2:0]] <= wr_merged;
      end
      ctrl_reg <= ctrl_next;
    end
  end

  // Item addresses from the live index
  logic [31:0] src_addr;
  logic [31:0] dst_addr;
  dmacc_addr_step #(.AW(32), .IW(16)) u_src_step (
    .start (src_start),
    .idx   (idx_reg),
    .inc   (src_inc),
    .width (width),
    .addr  (src_addr)
  );
  dmacc_addr_step #(.AW(32), .IW(16)) u_dst_step (
    .start (dst_start),
    .idx   (idx_reg),
    .inc   (dst_inc),
    .width (width),
    .addr  (dst_addr)
  );

  // Own request and level take this channel's slot in the arbiter
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_slot
      assign req_vec[g] = (g == CH_ID) ? own_req : PEER_REQ[g];
      assign prio_vec[g*3 +: 3] = (g == CH_ID) ? prio : PEER_PRIO[g*3 +: 3];
    end
  endgenerate

  dmacc_arbiter #(.NUM_CH(NUM_CH), .PW(PRIO_W)) u_arb (
    .req   (req_vec),
    .prio  (prio_vec),
    .grant (grant_vec)
  );

  // A fill run keeps the bus once won
  assign own_grant = hold_reg | grant_vec[CH_ID];

  // Transfer sequencer
  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    mem_next   = mem_reg;
    data_next  = data_reg;
    hold_next  = hold_reg;
    irq_next   = 1'b0;
    done_next  = 1'b0;
    run_clear  = 1'b0;
    own_req    = 1'b0;
    case (state_reg)
      S_IDLE: begin
        hold_next = 1'b0;
        idx_next  = 16'h0000;
        if (run) begin
          state_next = trig ? S_TRIG : S_ARB;
        end
      end
      S_TRIG: begin
        if (!run) begin
          state_next = S_IDLE;
        end else if (PERIPH_REQ) begin
          state_next = S_ARB;
        end
      end
      S_ARB: begin
        own_req = 1'b1;
        if (!run && !hold_reg) begin
          state_next = S_IDLE;
        end else if (own_grant) begin
          hold_next     = fill;
          mem_next.req  = 1'b1;
          mem_next.size = width;
          if (fill && idx_reg != 16'h0000) begin
            mem_next.we    = 1'b1;
            mem_next.addr  = dst_addr;
            mem_next.wdata = data_reg;
            state_next     = S_WRITE;
          end else begin
            mem_next.we    = 1'b0;
            mem_next.addr  = src_addr;
            mem_next.wdata = 32'h0000_0000;
            state_next     = S_READ;
          end
        end
      end
      S_READ: begin
        if (MEM_ACK) begin
          data_next      = MEM_RDATA;
          mem_next.we    = 1'b1;
          mem_next.addr  = dst_addr;
          mem_next.wdata = MEM_RDATA;
          state_next     = S_WRITE;
        end
      end
      S_WRITE: begin
        if (MEM_ACK) begin
          mem_next.req = 1'b0;
          irq_next     = irq_en && (idx_reg == icnt_w);
          if (last) begin
            done_next = 1'b1;
            idx_next  = 16'h0000;
            hold_next = 1'b0;
            if (keep) begin
              state_next = S_TRIG;
            end else begin
              run_clear  = 1'b1;
              state_next = S_IDLE;
            end
          end else begin
            idx_next = idx_reg + 16'h0001;
            // Blocking mode goes straight back to the bus; triggered mode waits in S_TRIG for the next request
            state_next = gap ? S_GAP : (trig ? S_TRIG : S_ARB);
          end
        end
      end
      S_GAP: begin
        state_next = S_ARB;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= S_IDLE;
      idx_reg   <= REG_RESET;
      mem_reg   <= '0;
      data_reg  <= 32'h0000_0000;
      hold_reg  <= 1'b0;
      irq_reg   <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      mem_reg   <= mem_next;
      data_reg  <= data_next;
      hold_reg  <= hold_next;
      irq_reg   <= irq_next;
      done_reg  <= done_next;
    end
  end

  // Lower masters are shut out unless yielding; a fill run always locks
  assign BUS_LOCK  = ((state_reg == S_READ || state_reg == S_WRITE) &&
                      (~yield | trig)) | hold_reg;
  assign MEM_OUT   = mem_reg;
  assign CH_IRQ    = irq_reg;
  assign CH_DONE   = done_reg;
  assign CH_ACTIVE = (state_reg != S_IDLE);

  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  chk_idx_clear: assert property (
    CH_DONE |-> idx_reg == 16'h0000)
    else $error("item index not cleared at completion");

  chk_len_last: assert property (
    CH_DONE |-> $past(idx_reg) == $past(len_w))
    else $error("completion before length plus one items");

  chk_irq_match: assert property (
    CH_IRQ |-> $past(idx_reg) == $past(icnt_w))
    else $error("interrupt without index match");

  chk_irq_gate: assert property (
    CH_IRQ |-> $past(irq_en))
    else $error("interrupt while disabled");

  chk_run_stop: assert property (
    CH_DONE && !$past(keep) && !$past(sw_ctrl) |-> !run && state_reg == S_IDLE)
    else $error("run bit kept after normal completion");

  chk_circ_keep: assert property (
    CH_DONE && $past(keep) |-> run && state_reg == S_TRIG)
    else $error("circular run did not restart");

  chk_gap_yield: assert property (
    state_reg == S_WRITE && MEM_ACK && gap && !last
    |=> state_reg == S_GAP ##1 state_reg == S_ARB)
    else $error("yield gap missing or too long");

  chk_trig_wait: assert property (
    state_reg == S_TRIG && !PERIPH_REQ |=> state_reg != S_ARB)
    else $error("transfer started without peripheral request");

  chk_fill_once: assert property (
    hold_reg && state_reg == S_ARB && idx_reg != 16'h0000
    |=> state_reg == S_WRITE && MEM_OUT.we)
    else $error("fill mode fetched the source again");

  chk_av_answer: assert property (
    AV_IN.read && AV_WAITREQUEST |=> !AV_WAITREQUEST)
    else $error("register read not answered on second edge");

endmodule

// ---- hw/dmacc_pkg.sv ----
package dmacc_pkg;

  // Register offsets as printed; each is kept as a named constant
  localparam logic [31:0] OFF_ITEM_IDX = 32'h5000_353e;
  localparam logic [31:0] OFF_SRC_LO   = 32'h5000_3540;
  localparam logic [31:0] OFF_SRC_HI   = 32'h5000_3542;
  localparam logic [31:0] OFF_DST_LO   = 32'h5000_3544;
  localparam logic [31:0] OFF_DST_HI   = 32'h5000_3546;
  localparam logic [31:0] OFF_INT_CNT  = 32'h5000_3548;
  localparam logic [31:0] OFF_LEN      = 32'h5000_354a;
  localparam logic [31:0] OFF_CTRL     = 32'h5000_354c;

  // Word index on the slave port; byte offset is twice the index
  localparam int unsigned AV_AW = 4;
  localparam logic [3:0] RI_ITEM_IDX = 4'((OFF_ITEM_IDX - OFF_ITEM_IDX) >> 1);
  localparam logic [3:0] RI_SRC_LO   = 4'((OFF_SRC_LO - OFF_ITEM_IDX) >> 1);
  localparam logic [3:0] RI_SRC_HI   = 4'((OFF_SRC_HI - OFF_ITEM_IDX) >> 1);
  localparam logic [3:0] RI_DST_LO   = 4'((OFF_DST_LO - OFF_ITEM_IDX) >> 1);
  localparam logic [3:0] RI_DST_HI   = 4'((OFF_DST_HI - OFF_ITEM_IDX) >> 1);
  localparam logic [3:0] RI_INT_CNT  = 4'((OFF_INT_CNT - OFF_ITEM_IDX) >> 1);
  localparam logic [3:0] RI_LEN      = 4'((OFF_LEN - OFF_ITEM_IDX) >> 1);
  localparam logic [3:0] RI_CTRL     = 4'((OFF_CTRL - OFF_ITEM_IDX) >> 1);

  // Control field positions
  localparam int CB_RUN     = 0;
  localparam int CB_WIDTH   = 1;
  localparam int CB_IRQ_EN  = 3;
  localparam int CB_TRIG    = 4;
  localparam int CB_DST_INC = 5;
  localparam int CB_SRC_INC = 6;
  localparam int CB_CIRC    = 7;
  localparam int CB_PRIO    = 8;
  localparam int CB_YIELD   = 11;
  localparam int CB_FILL    = 12;
  localparam int PRIO_W     = 3;

  // Writable control bits; 15:13 stay zero
  localparam logic [15:0] CTRL_WMASK = 16'h1fff;
  localparam logic [15:0] REG_RESET  = 16'h0000;
  localparam logic [1:0]  WIDTH_RSVD = 2'h3;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_TRIG = 3'h1,
    S_ARB  = 3'h2,
    S_READ = 3'h3,
    S_WRITE = 3'h4,
    S_GAP  = 3'h5
  } dmacc_state_t;

  // System bus request carried by the channel
  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dmacc_mem_t;

  // Avalon-MM request from the register master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } dmacc_av_t;

endpackage

// ---- verification/dmacc_mem_model.sv ----
`timescale 1ns/1ps
module dmacc_mem_model
  import dmacc_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Channel request and pacing choice
  input  wire dmacc_mem_t MEM,
  input  wire logic       SLOW,
  // Answer to the channel
  output logic [31:0]     RDATA,
  output logic            ACK
);
  logic [1:0]  wait_reg;
  logic [31:0] last_reg;
  integer      seed = 7;

  // Content is a hash of the byte address, so every item differs
  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return (a * 32'h9e37_79b9) ^ 32'h5a5a_0000;
  endfunction

  // One access at a time; ack after none or a few random idle cycles
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ACK      <= 1'b0;
      wait_reg <= 2'h0;
      last_reg <= 32'h0000_0000;
    end else if (ACK) begin
      ACK      <= 1'b0;
      wait_reg <= SLOW ? 2'($random(seed)) : 2'h0;
    end else if (MEM.req && wait_reg != 2'h0) begin
      wait_reg <= wait_reg - 2'h1;
    end else if (MEM.req) begin
      ACK      <= 1'b1;
      last_reg <= mem_word(MEM.addr);
    end
  end

  // Outside the ack cycle the lines carry junk, never stale data
  assign RDATA = ACK ? last_reg : ~last_reg;
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
  import dmacc_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, slow = 1'b0, preq = 1'b0;
  logic        lock, irq, done, act, ack, wreq;
  dmacc_av_t   av = '0;
  dmacc_mem_t  mo;
  logic [31:0] rd, rdata;
  logic [7:0]  peer = 8'h00;
  logic [23:0] pprio = 24'h00_0000;
  int          fail_count = 0, n_compared = 0, seed = 53840;
  int          n_done = 0, n_irq = 0, yld = 0, w = 0, fill = 0;
  logic [31:0] fq[$], sq[$], dq[$];

  always #2 clk = ~clk;

  dmacc_channel #(.NUM_CH(8), .CH_ID(2)) dut (.CLK(clk), .RST(rst), .AV_IN(av),
    .AV_READDATA(rd), .AV_WAITREQUEST(wreq), .MEM_OUT(mo), .MEM_RDATA(rdata),
    .MEM_ACK(ack), .BUS_LOCK(lock), .PERIPH_REQ(preq), .PEER_REQ(peer),
    .PEER_PRIO(pprio), .CH_IRQ(irq), .CH_DONE(done), .CH_ACTIVE(act));
  dmacc_mem_model mem (.CLK(clk), .RST(rst), .MEM(mo), .SLOW(slow), .RDATA(rdata),
    .ACK(ack));

  // Log finished accesses and count event pulses
  always @(posedge clk) if (!rst) begin
    if (mo.req && ack) begin
      if (mo.we) begin
        sq.push_back(mo.addr);
        dq.push_back(mo.wdata);
      end else fq.push_back(mo.addr);
      `CHK("bus lock", (yld == 0 || fill != 0) ? 1'b1 : 1'b0, lock)
      `CHK("item size", 2'(w), mo.size)
    end
    if (done === 1'b1) n_done++;
    if (irq === 1'b1) n_irq++;
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Avalon cycle: hold everything until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    av.read <= ~wr;
    av.write <= wr;
    av.address <= a;
    av.byteenable <= 4'hf;
    av.writedata <= {16'h0000, d};
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rd;
    av.read <= 1'b0;
    av.write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    `CHK("register", e, q)
  endtask

  task automatic set_regs(input logic [31:0] s, d, input logic [15:0] len, m, c);
    wr(RI_SRC_LO, s[15:0]);
    wr(RI_SRC_HI, s[31:16]);
    wr(RI_DST_LO, d[15:0]);
    wr(RI_DST_HI, d[31:16]);
    wr(RI_INT_CNT, m);
    wr(RI_LEN, len);
    wr(RI_CTRL, c);
  endtask

  task automatic wait_done(input int target);
    int n;
    n = 0;
    while (n_done < target && n < 3000) begin
      @(posedge clk);
      n++;
    end
    `CHK("done pulses", target, n_done)
  endtask

  // Expected address and data sequence of one finished transfer
  task automatic check_xfer(input logic [31:0] s, d, input int len, w, si, di, fill);
    logic [31:0] fa;
    `CHK("fetch count", fill ? 1 : len + 1, fq.size())
    `CHK("store count", len + 1, sq.size())
    for (int i = 0; i <= len && i < sq.size(); i++) begin
      fa = s + ((si != 0 && fill == 0) ? (i << w) : 0);
      if (fill == 0 || i == 0) `CHK("fetch addr", fa, fq[i])
      `CHK("store addr", d + (di != 0 ? (i << w) : 0), sq[i])
      `CHK("store data", mem.mem_word(fill ? s : fa), dq[i])
    end
    fq.delete();
    sq.delete();
    dq.delete();
  endtask

  // Hang guard sized well above the whole sequence
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    $display("Error watchdog expected finish seen timeout");
    conclude();
  end

  initial begin
    logic [31:0] s, d;
    logic [15:0] c, v;
    int len, m, si, di, ie, n0, i0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Reset values, read-back, read-only and unmapped places
    for (int i = 0; i < 9; i++) rdchk(4'(i), 32'h0000_0000);
    for (int i = 1; i < 7; i++) begin
      v = 16'($random(seed));
      wr(4'(i), v);
      rdchk(4'(i), {16'h0000, v});
    end
    wr(RI_ITEM_IDX, 16'hbeef);
    rdchk(RI_ITEM_IDX, 32'h0000_0000);
    wr(RI_CTRL, 16'hfffe);
    rdchk(RI_CTRL, 32'h0000_1ffe);
    `CHK("no run while off", 0, fq.size())
    wr(4'hc, 16'h1234);
    rdchk(4'hc, 32'h0000_0000);
    wr(RI_CTRL, 16'h0000);
    $display("test registers done");
    // Free-running copies and fills with random settings
    for (int t = 0; t < 18; t++) begin
      w = t % 3;
      fill = (t % 4 == 3);
      len = (t == 0) ? 0 : ($random(seed) & 3);
      m = $random(seed) & 3;
      si = $random(seed) & 1;
      di = fill | ($random(seed) & 1);
      ie = $random(seed) & 1;
      yld = $random(seed) & 1;
      slow <= 1'($random(seed));
      if (t == 17) begin
        len = 9;
        m = 9;
        ie = 1;
      end
      s = $random(seed);
      d = $random(seed);
      c = 16'(1 | w << 1 | ie << 3 | di << 5 | si << 6 | ($random(seed) & 7) << 8);
      c = c | 16'(yld << 11 | fill << 12);
      n0 = n_done;
      i0 = n_irq;
      set_regs(s, d, 16'(len), 16'(m), c);
      wait_done(n0 + 1);
      `CHK("irq pulses", (ie != 0 && m <= len) ? 1 : 0, n_irq - i0)
      check_xfer(s, d, len, w, si, di, fill);
      `CHK("idle after stop", 1'b0, act)
      rdchk(RI_CTRL, {16'h0000, c & 16'hfffe});
      rdchk(RI_ITEM_IDX, 32'h0000_0000);
    end
    $display("test copies done");
    // Triggered circular run; yield bit set but ignored, fill kept off
    yld = 0;
    w = 0;
    fill = 0;
    slow <= 1'b0;
    n0 = n_done;
    set_regs(32'h0000_1000, 32'h0000_2000, 16'h0001, 16'h0000, 16'h08f1);
    repeat (20) @(posedge clk);
    `CHK("idle before trigger", 0, fq.size())
    `CHK("waiting for trigger", 1'b1, act)
    for (int k = 0; k < 3; k++) begin
      preq <= 1'b1;
      @(posedge clk);
      preq <= 1'b0;
      repeat (20) @(posedge clk);
      `CHK("items per trigger", k + 1, sq.size())
      rdchk(RI_ITEM_IDX, 32'((k + 1) % 2));
    end
    `CHK("circular pass", n0 + 1, n_done)
    `CHK("restart addr", 32'h0000_1000, fq[2])
    rdchk(RI_CTRL, 32'h0000_08f1);
    wr(RI_CTRL, 16'h0000);
    fq.delete();
    sq.delete();
    dq.delete();
    $display("test trigger done");
    // Arbitration against peers: higher level, equal lower number, then win over lower level and higher number
    pprio <= 24'(4 << 15 | 3 << 9 | 3 << 3 | 2);
    peer <= 8'h22;
    n0 = n_done;
    set_regs(32'h0000_4000, 32'h0000_5000, 16'h0000, 16'h0000, 16'h0361);
    repeat (20) @(posedge clk);
    `CHK("higher level wins", 0, fq.size())
    peer <= 8'h02;
    repeat (20) @(posedge clk);
    `CHK("lower number wins", 0, fq.size())
    peer <= 8'h09;
    wait_done(n0 + 1);
    check_xfer(32'h0000_4000, 32'h0000_5000, 0, 0, 1, 1, 0);
    peer <= 8'h00;
    $display("test priority done");
    conclude();
  end
endmodule
